// >>> include/cstseq_defs.svh
/*
  Constants for the self-test sequencer: error codes, step count, band count.
  Assumes nothing of its surroundings; definitions only.
*/
`ifndef CSTSEQ_DEFS_SVH
`define CSTSEQ_DEFS_SVH
`define CST_ERR_NONE 8'h00
`define CST_ERR_FWLOAD 8'h13
`define CST_ERR_DRBG_A 8'h18
`define CST_ERR_DRBG_B 8'h19
`define CST_ERR_XTS 8'h23
`define CST_ERR_CBC 8'h24
`define CST_ERR_SHA 8'h25
`define CST_ERR_HMAC 8'h26
`define CST_ERR_RSA 8'h27
`define CST_ERR_KDF 8'h28
`define CST_ERR_RCT 8'h2c
`define CST_ERR_APT 8'h2d
`define CST_ERR_ECDSA 8'h36
`define CST_NUM_KAT 9
`define CST_NUM_BANDS 8
`define CST_NUM_SETUP 6
`endif

// >>> include/cstseq_pkg.sv
/*
  Types for the self-test sequencer.
  Assumes the defs header is compiled alongside.
*/
package cstseq_pkg;
  // Engine result for one self-test step: done, verdict, sub-test flag
  typedef struct packed {
    logic done;
    logic pass;
    logic subFail;
  } cstseq_result_s;
  // Noise-source health result
  typedef struct packed {
    logic done;
    logic rctFail;
    logic aptFail;
  } cstseq_health_s;
  typedef enum logic [3:0] {
    ST_CRC, ST_KAT, ST_NOISE, ST_FWCHK, ST_SETUP, ST_APPROVED,
    ST_ECTEST, ST_ENTCHK, ST_DLCHK, ST_BOOTERR, ST_LOADERR, ST_ERR, ST_HALT
  } cstseq_state_e;
endpackage : cstseq_pkg

// >>> core/cstseq_top.sv
/*
  Self-test sequencer: runs power-on tests, conditional tests and holds the
  error state until power-off. Assumes test engines answer with a one-cycle
  done pulse plus verdict, and that rst_n is the power-on reset.
*/
// Contract
// - Power-on AES-256 CBC test; failure gives boot error code 0x24.
// - Power-on AES-256 XTS test; failure gives boot error code 0x23.
// - Power-on SHA2-256/384 tests; failure gives boot error code 0x25.
// - Power-on HMAC-SHA2-256 test; failure gives boot error code 0x26.
// - Power-on RSA signature-verify test; failure gives boot error 0x27.
// - Power-on counter KDF test; failure gives boot error code 0x28.
// - ECDSA test before first signing use; failure gives error 0x36.
// - Startup noise health tests; failure gives boot error 0x2C/0x2D.
// - Noise health tests each entropy request; failure gives error 0x2C/0x2D.
// - Power-on firmware signature check; failure enters load error, 0x13.
// - Failed download check reports 0x13, then resumes with old firmware.
// - Boot ROM CRC mismatch halts startup, with no other indication.
// - Tests start on their own at startup and before security functions.
// - Reset (power cycle) reruns the full self-test set.
// - Error state persists until power-off; power-on reruns all tests.
// - After setup succeeds enter approved mode and flag success.
// - Configured bands come up locked at power-on.
// - Unconfigured bands are treated as unprotected plaintext.
`timescale 1ns/1ps
`include "cstseq_defs.svh"
module cstseq_top
  import cstseq_pkg::*;
#(
  parameter int NumKat = `CST_NUM_KAT,
  parameter int NumBands = `CST_NUM_BANDS
) (
  // Clock and power-on reset
  input wire logic clock,
  input wire logic rst_n,
  // Boot ROM CRC checker
  output logic crcStart,
  input wire cstseq_result_s crcRes,
  // Algorithm test engines, one per power-on step
  output logic [NumKat-1:0] katStart,
  input wire cstseq_result_s [NumKat-1:0] katRes,
  // Noise source health tests
  output logic noiseStart,
  input wire cstseq_health_s noiseRes,
  // Firmware signature checker
  output logic fwStart,
  input wire cstseq_result_s fwRes,
  // ECDSA test engine
  output logic ecStart,
  input wire cstseq_result_s ecRes,
  // Controller requests
  input wire logic ecUseReq,
  input wire logic entropyReq,
  input wire logic dlVerifyReq,
  input wire logic setupStepDone,
  input wire logic [2:0] setupStepIdx,
  input wire logic [NumBands-1:0] bandConfigured,
  // Status and gating outputs
  output logic ecGrant,
  output logic entropyGrant,
  output logic dlReject,
  output logic approved,
  output logic errorActive,
  output logic cryptoEnable,
  output logic [7:0] errCode,
  output logic [NumBands-1:0] bandLocked,
  output logic [NumBands-1:0] bandPlaintext
);

  // Error code of each power-on step, in run order
  function automatic logic [7:0] katCode(input logic [3:0] idx, input logic sub);
    case (idx)
      4'h0: katCode = `CST_ERR_CBC;
      4'h1: katCode = `CST_ERR_XTS;
      4'h2: katCode = `CST_ERR_SHA; // SHA2-256
      4'h3: katCode = `CST_ERR_SHA; // SHA2-384
      4'h4: katCode = `CST_ERR_HMAC;
      4'h5: katCode = sub ? `CST_ERR_DRBG_B : `CST_ERR_DRBG_A;
      4'h6: katCode = `CST_ERR_RSA;
      4'h7: katCode = `CST_ERR_KDF;
      default: katCode = `CST_ERR_KDF;
    endcase
  endfunction : katCode

  // Noise failure code: repetition count wins over proportion
  function automatic logic [7:0] noiseCode(input cstseq_health_s h);
    noiseCode = h.rctFail ? `CST_ERR_RCT : `CST_ERR_APT;
  endfunction : noiseCode

  cstseq_state_e state_q, state_d;
  logic [3:0] katIdx_q, katIdx_d;
  logic [2:0] setupIdx_q, setupIdx_d;
  logic [7:0] err_q, err_d;
  logic ecTested_q, ecTested_d;
  logic launched_q, launched_d;
  logic served_q, served_d;
  logic ecGrant_d, entGrant_d, dlRej_d;
  logic [NumKat-1:0] katStart_d;
  logic crcStart_d, noiseStart_d, fwStart_d, ecStart_d;

  // Current step result and failure flags
  wire cstseq_result_s katCur = katRes[katIdx_q];
  wire noiseBad = noiseRes.rctFail | noiseRes.aptFail;
  wire lastKat = (katIdx_q == 4'(NumKat - 1));
  wire setupOk = setupStepDone && (setupIdx_q == setupStepIdx);
  wire anyReq = ecUseReq || entropyReq || dlVerifyReq;
  wire errState = (state_q == ST_BOOTERR) || (state_q == ST_LOADERR) || (state_q == ST_ERR);

  // Sequencer: each step issues one start pulse then waits for done
  always_comb begin
    state_d = state_q;
    katIdx_d = katIdx_q;
    setupIdx_d = setupIdx_q;
    err_d = err_q;
    ecTested_d = ecTested_q;
    launched_d = 1'b1;
    served_d = served_q && anyReq; // Answer flag clears once requests drop
    ecGrant_d = 1'b0;
    entGrant_d = 1'b0;
    dlRej_d = 1'b0;
    katStart_d = '0;
    crcStart_d = 1'b0;
    noiseStart_d = 1'b0;
    fwStart_d = 1'b0;
    ecStart_d = 1'b0;
    case (state_q)
      ST_CRC: begin
        crcStart_d = !launched_q;
        if (crcRes.done) begin
          launched_d = 1'b0;
          state_d = crcRes.pass ? ST_KAT : ST_HALT;
        end
      end
      ST_KAT: begin
        katStart_d[katIdx_q] = !launched_q;
        if (katCur.done) begin
          launched_d = 1'b0;
          if (!katCur.pass) begin
            err_d = katCode(katIdx_q, katCur.subFail);
            state_d = ST_BOOTERR;
          end else if (lastKat) begin
            state_d = ST_NOISE;
          end else begin
            katIdx_d = katIdx_q + 4'h1;
          end
        end
      end
      ST_NOISE: begin
        noiseStart_d = !launched_q;
        if (noiseRes.done) begin
          launched_d = 1'b0;
          if (noiseBad) begin
            err_d = noiseCode(noiseRes);
            state_d = ST_BOOTERR;
          end else begin
            state_d = ST_FWCHK;
          end
        end
      end
      ST_FWCHK: begin
        fwStart_d = !launched_q;
        if (fwRes.done) begin
          launched_d = 1'b0;
          if (!fwRes.pass) begin
            err_d = `CST_ERR_FWLOAD;
            state_d = ST_LOADERR;
          end else begin
            state_d = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        // Out-of-order steps are ignored; controller owns the order
        if (setupOk) begin
          setupIdx_d = setupIdx_q + 3'h1;
          if (setupIdx_q == 3'(`CST_NUM_SETUP - 1)) begin
            state_d = ST_APPROVED;
          end
        end
      end
      ST_APPROVED: begin
        // One request served at a time; ECDSA first-use test has priority.
        // A request still held from its last answer waits for a drop first,
        // else one level request would be served twice.
        if (served_q) begin
          state_d = ST_APPROVED;
        end else if (ecUseReq) begin
          if (ecTested_q) begin
            ecGrant_d = 1'b1;
            served_d = 1'b1;
          end else begin
            launched_d = 1'b0;
            state_d = ST_ECTEST;
          end
        end else if (entropyReq) begin
          launched_d = 1'b0;
          state_d = ST_ENTCHK;
        end else if (dlVerifyReq) begin
          launched_d = 1'b0;
          state_d = ST_DLCHK;
        end
      end
      ST_ECTEST: begin
        ecStart_d = !launched_q;
        if (ecRes.done) begin
          launched_d = 1'b0;
          if (!ecRes.pass) begin
            err_d = `CST_ERR_ECDSA;
            state_d = ST_ERR;
          end else begin
            ecTested_d = 1'b1;
            state_d = ST_APPROVED;
          end
        end
      end
      ST_ENTCHK: begin
        noiseStart_d = !launched_q;
        if (noiseRes.done) begin
          launched_d = 1'b0;
          if (noiseBad) begin
            err_d = noiseCode(noiseRes);
            state_d = ST_ERR;
          end else begin
            entGrant_d = 1'b1;
            served_d = 1'b1;
            state_d = ST_APPROVED;
          end
        end
      end
      ST_DLCHK: begin
        fwStart_d = !launched_q;
        if (fwRes.done) begin
          launched_d = 1'b0;
          state_d = ST_APPROVED;
          served_d = 1'b1;
          if (!fwRes.pass) begin
            err_d = `CST_ERR_FWLOAD;
            dlRej_d = 1'b1;
          end
        end
      end
      // Error and halt states only leave through power-on reset
      ST_BOOTERR, ST_LOADERR, ST_ERR, ST_HALT: begin
        state_d = state_q;
      end
      default: begin
        state_d = ST_HALT;
      end
    endcase
  end

  // Sequencer state; power-on reset restarts the whole test set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_CRC;
      katIdx_q <= 4'h0;
      setupIdx_q <= 3'h0;
      err_q <= `CST_ERR_NONE;
      ecTested_q <= 1'b0;
      launched_q <= 1'b0;
      served_q <= 1'b0;
    end else begin
      state_q <= state_d;
      katIdx_q <= katIdx_d;
      setupIdx_q <= setupIdx_d;
      err_q <= err_d;
      ecTested_q <= ecTested_d;
      launched_q <= launched_d;
      served_q <= served_d;
    end
  end

  // Registered outputs and start pulses
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crcStart <= 1'b0;
      katStart <= '0;
      noiseStart <= 1'b0;
      fwStart <= 1'b0;
      ecStart <= 1'b0;
      ecGrant <= 1'b0;
      entropyGrant <= 1'b0;
      dlReject <= 1'b0;
    end else begin
      crcStart <= crcStart_d;
      katStart <= katStart_d;
      noiseStart <= noiseStart_d;
      fwStart <= fwStart_d;
      ecStart <= ecStart_d;
      ecGrant <= ecGrant_d && !errState;
      entropyGrant <= entGrant_d && !errState;
      dlReject <= dlRej_d;
    end
  end

  // Status outputs, one cycle behind the state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      approved <= 1'b0;
      errorActive <= 1'b0;
      cryptoEnable <= 1'b0;
      errCode <= `CST_ERR_NONE;
    end else begin
      approved <= (state_q == ST_APPROVED);
      errorActive <= errState;
      cryptoEnable <= (state_q == ST_APPROVED) && !errState;
      errCode <= err_q;
    end
  end

  // Band protection: configured bands locked from power-on
  genvar b;
  generate
    for (b = 0; b < NumBands; b++) begin : gBand
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          bandLocked[b] <= 1'b1;
          bandPlaintext[b] <= 1'b0;
        end else begin
          bandLocked[b] <= bandConfigured[b];
          bandPlaintext[b] <= !bandConfigured[b];
        end
      end
    end
  endgenerate

endmodule : cstseq_top

// >>> sim/cstseq_props.sv
/* Port checker for the self-test sequencer.
   Assumes it is bound to cstseq_top. */
`timescale 1ns/1ps
module cstseq_props
  import cstseq_pkg::*;
#(
  parameter int NumKat = 9,
  parameter int NumBands = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Engine side
  input wire logic [NumKat-1:0] katStart,
  input wire cstseq_result_s crcRes,
  input wire cstseq_health_s noiseRes,
  input wire cstseq_result_s ecRes,
  // Status side
  input wire logic entropyReq,
  input wire logic entropyGrant,
  input wire logic dlReject,
  input wire logic approved,
  input wire logic errorActive,
  input wire logic cryptoEnable,
  input wire logic [7:0] errCode,
  input wire logic [NumBands-1:0] bandLocked,
  input wire logic [NumBands-1:0] bandPlaintext
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // A ROM mismatch shows only as a stalled startup
  sequence sHalted;
    (!errorActive && !approved && katStart == '0) [*8];
  endsequence
  sequence sErr(logic [7:0] c);
    errorActive && !cryptoEnable && errCode == c;
  endsequence
  a_crc_halts: assert property (crcRes.done && !crcRes.pass |=> sHalted)
    else $error("startup went on");
  a_kat_follows: assert property (crcRes.done && crcRes.pass |-> ##2 katStart[0])
    else $error("first test not started");
  a_error_blocks: assert property (errorActive |-> !cryptoEnable && !approved)
    else $error("service open in error");
  a_error_sticky: assert property (errorActive |=> errorActive && $stable(errCode))
    else $error("error state left");
  a_noise_rct: assert property (noiseRes.done && noiseRes.rctFail |-> ##2 sErr(8'h2c))
    else $error("noise fault not flagged");
  a_ec_fail: assert property (ecRes.done && !ecRes.pass |-> ##2 sErr(8'h36))
    else $error("ec fault not flagged");
  a_grant_gated: assert property (entropyGrant |-> entropyReq && !errorActive)
    else $error("entropy given unasked");
  a_dl_keeps: assert property (dlReject |-> !errorActive ##[0:1] errCode == 8'h13)
    else $error("download reject wrong");
  a_band_view: assert property (bandPlaintext == ~bandLocked)
    else $error("band view split");
endmodule : cstseq_props

bind cstseq_top cstseq_props #(.NumKat(NumKat), .NumBands(NumBands)) uProps (.*);

// >>> sim/cstseq_engines.sv
/* Model of the test engines and noise source.
   Assumes one-cycle starts; the bench picks the failing step. */
`timescale 1ns/1ps
module cstseq_engines
  import cstseq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Starts
  input wire logic crcStart,
  input wire logic [8:0] katStart,
  input wire logic noiseStart,
  input wire logic fwStart,
  input wire logic ecStart,
  // Bench control
  input wire logic [3:0] failIdx,
  input wire logic sub,
  input wire logic slow,
  // Results
  output cstseq_result_s crcRes,
  output cstseq_result_s [8:0] katRes,
  output cstseq_health_s noiseRes,
  output cstseq_result_s fwRes,
  output cstseq_result_s ecRes
);
  logic [12:0] d1, d2, d3, done;
  logic tog;
  // Slow mode makes every step wait longer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {d1, d2, d3} <= '0;
      tog <= 1'b0;
    end else begin
      d1 <= {ecStart, fwStart, noiseStart, katStart, crcStart};
      d2 <= d1;
      d3 <= d2;
      tog <= ~tog;
    end
  end
  assign done = slow ? d3 : d1;
  // Verdicts toggle outside done so stale bits never look valid
  function automatic cstseq_result_s res(int i);
    logic f;
    f = failIdx == 4'(i);
    return done[i] ? {1'b1, !f, sub} : {1'b0, tog, ~tog};
  endfunction
  always_comb begin
    crcRes = res(0);
    for (int k = 0; k < 9; k++) katRes[k] = res(k + 1);
    noiseRes = {done[10], tog ^ done[10], tog};
    if (done[10]) noiseRes[1:0] = {failIdx == 4'ha && sub, failIdx == 4'ha};
    fwRes = res(11);
    ecRes = res(12);
  end
endmodule : cstseq_engines

// >>> sim/testbench.sv
/* Self-checking bench for the self-test sequencer.
   Assumes the engine model and checker are compiled alongside. */
`timescale 1ns/1ps
module testbench;
  import cstseq_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, sub = 1'b0, slow = 1'b0;
  logic ecUseReq = 1'b0, entropyReq = 1'b0, dlVerifyReq = 1'b0, setupStepDone = 1'b0;
  logic [2:0] setupStepIdx = 3'h0;
  logic [3:0] failIdx = 4'hf;
  logic [7:0] bandConfigured = 8'h00, errCode, bandLocked, bandPlaintext;
  logic crcStart, noiseStart, fwStart, ecStart, ecGrant, entropyGrant, dlReject;
  logic approved, errorActive, cryptoEnable;
  logic [8:0] katStart;
  cstseq_result_s crcRes, fwRes, ecRes;
  cstseq_result_s [8:0] katRes;
  cstseq_health_s noiseRes;
  logic [31:0] rng = 32'h000139b8;
  int errors = 0, checked = 0;
  cstseq_top DUT (.*);
  cstseq_engines uEng (.*);
  initial forever #2 clock = ~clock;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Code for a failing step; none for the ROM check
  function automatic logic [7:0] expCode(logic [3:0] f, logic s);
    case (f)
      4'h1: return 8'h24;
      4'h2: return 8'h23;
      4'h3, 4'h4: return 8'h25;
      4'h5: return 8'h26;
      4'h6: return s ? 8'h19 : 8'h18;
      4'h7: return 8'h27;
      4'h8, 4'h9: return 8'h28;
      4'ha: return s ? 8'h2c : 8'h2d;
      4'hb: return 8'h13;
      default: return 8'h00;
    endcase
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Power cycle with one step failing, then setup with a stray step first
  task automatic boot(logic [3:0] f, logic s);
    rng = xs(rng);
    rst_n <= 1'b0;
    failIdx <= f;
    sub <= s;
    slow <= rng[0];
    bandConfigured <= rng[15:8];
    repeat (16) @(posedge clock);
    check("lockReset", bandLocked, 8'hff);
    rst_n <= 1'b1;
    repeat (100) @(posedge clock);
    for (int i = 0; i < 7; i++) begin
      setupStepDone <= 1'b1;
      setupStepIdx <= i == 0 ? 3'h5 : 3'(i - 1);
      @(posedge clock);
      setupStepDone <= 1'b0;
      @(posedge clock);
    end
    repeat (4) @(posedge clock);
    check("approved", approved, f == 4'hf);
    check("enable", cryptoEnable, f == 4'hf);
    check("error", errorActive, f != 4'hf && f != 4'h0);
    check("code", errCode, expCode(f, s));
    check("locked", bandLocked, bandConfigured);
  endtask : boot
  // Hold one request until answered or failed; k 2 ec, 1 entropy, 0 download
  task automatic request(int k, logic [2:0] exp);
    logic [2:0] seen;
    seen = 3'h0;
    {ecUseReq, entropyReq, dlVerifyReq} <= 3'(1 << k);
    for (int n = 0; n < 40 && seen == 3'h0 && !errorActive; n++) begin
      @(posedge clock);
      seen = {ecGrant, entropyGrant, dlReject};
    end
    {ecUseReq, entropyReq, dlVerifyReq} <= 3'h0;
    @(posedge clock);
    check("answer", seen, exp);
  endtask : request
  initial begin
    for (int k = 0; k < 24; k++)
      boot(4'(k / 2), k[0]);
    boot(4'hf, 1'b0);
    failIdx <= 4'hc;
    request(2, 3'h0);
    check("ecCode", errCode, 8'h36);
    boot(4'hf, 1'b0);
    failIdx <= 4'ha;
    sub <= rng[1];
    request(1, 3'h0);
    check("noiseCode", errCode, rng[1] ? 8'h2c : 8'h2d);
    boot(4'hf, 1'b0);
    for (int i = 0; i < 3; i++) begin
      request(2, 3'h4);
      request(1, 3'h2);
    end
    failIdx <= 4'hb;
    request(0, 3'h1);
    repeat (4) @(posedge clock);
    check("dlCode", errCode, 8'h13);
    check("dlStay", approved, 1'b1);
    end_sim;
  end
  // Runs need about 4000 cycles; far beyond that is a hang
  initial begin
    repeat (9000) @(posedge clock);
    errors++;
    end_sim;
  end
endmodule : testbench
